// >>> rtl/pic_top.sv
// Local design decision: the APB register port.
`timescale 1ns/10ps
module pic_top
	import pic_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	input wire pic_events_t ev_in,
	output logic irq_pin,
	output logic sys_irq
);

	// ==========================================
	// state
	pic_state_t s_r;
	pic_state_t s_nxt;

	logic [7:0] idx;
	logic setup;
	logic wr;
	logic rd;
	logic mapped;
	logic [15:0] wdat;
	logic [15:0] lev_set;
	logic [15:0] mev_set;
	logic link_hit;
	logic mon_hit;
	logic assert_req;
	logic [2:0] sys_set;

	assign idx = paddr[9:2];
	assign setup = psel && !penable;
	// writes commit in the access cycle; ready is always high there
	assign wr = psel && penable && pwrite;
	assign rd = setup && !pwrite;
	assign wdat = {pstrb[1] ? pwdata[15:8] : 8'h00,
		pstrb[0] ? pwdata[7:0] : 8'h00};
	assign mapped = (paddr[31:10] == 22'h00_0000) && (paddr[1:0] == 2'b00)
		&& (idx >= PIC_IDX_SUMMARY) && (idx <= PIC_IDX_IRQ_EN);

	always_comb
	begin
		lev_set = ev_in.lev & PIC_LINK_FLAGS;
		mev_set = ev_in.mev & PIC_MON_FLAGS;
		// any flag whose enable (8 bits lower) is on
		link_hit = |(s_r.link_reg[15:8] & s_r.link_reg[7:0]
			& PIC_LINK_FLAGS[15:8]);
		mon_hit = |(s_r.mon_reg[15:8] & s_r.mon_reg[7:0]
			& PIC_MON_FLAGS[15:8]);
		assert_req = s_r.pin_ctrl[PIC_FORCE_BIT]
			|| (s_r.pin_ctrl[PIC_GEN_BIT] && (link_hit || mon_hit));
		sys_set = 3'h0;
		sys_set[PIC_SYS_SUMMARY] = assert_req;
		sys_set[PIC_SYS_LINK] = |lev_set;
		sys_set[PIC_SYS_MON] = |mev_set;
	end

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;

		// read data is captured in setup, so clear-on-read can act there
		if (rd)
		begin
			s_nxt.prdata = 32'h0000_0000;
			// refused addresses read as zero, even a misaligned mapped index
			case (mapped ? idx : 8'h00)
				PIC_IDX_SUMMARY:
					s_nxt.prdata[PIC_SUMMARY_BIT] = s_r.summary;
				PIC_IDX_PIN_CTRL:
					s_nxt.prdata[15:0] = s_r.pin_ctrl;
				PIC_IDX_LINK_EV:
					s_nxt.prdata[15:0] = s_r.link_reg;
				PIC_IDX_MON_EV:
					s_nxt.prdata[15:0] = s_r.mon_reg;
				PIC_IDX_IRQ_STAT:
					s_nxt.prdata[2:0] = s_r.sys_stat;
				PIC_IDX_IRQ_EN:
					s_nxt.prdata[2:0] = s_r.sys_en;
				default:
					s_nxt.prdata = 32'h0000_0000;
			endcase
		end
		if (setup)
			s_nxt.pready = 1'b1;
		if (setup && !mapped)
			s_nxt.pslverr = 1'b1;

		// clear on read; a new event in the same cycle still wins
		if (rd && mapped && idx == PIC_IDX_LINK_EV)
			s_nxt.link_reg[15:8] = 8'h00;
		if (rd && mapped && idx == PIC_IDX_MON_EV)
			s_nxt.mon_reg[15:8] = 8'h00;
		if (rd && mapped && idx == PIC_IDX_SUMMARY)
			s_nxt.summary = 1'b0;

		if (wr && mapped)
		begin
			case (idx)
				PIC_IDX_PIN_CTRL:
					s_nxt.pin_ctrl = wdat & PIC_PIN_CTRL_RST
						| wdat & 16'h0004;
				PIC_IDX_LINK_EV:
					s_nxt.link_reg[7:0] = wdat[7:0] & PIC_LINK_MASKS[7:0];
				PIC_IDX_MON_EV:
					s_nxt.mon_reg[7:0] = wdat[7:0] & PIC_MON_MASKS[7:0];
				PIC_IDX_IRQ_CLR:
					s_nxt.sys_stat = s_r.sys_stat & ~wdat[2:0];
				PIC_IDX_IRQ_EN:
					s_nxt.sys_en = wdat[2:0];
				default:
					s_nxt.sys_en = s_nxt.sys_en;
			endcase
		end

		// sticky sets last so they beat any clear
		s_nxt.link_reg[15:8] = s_nxt.link_reg[15:8] | lev_set[15:8];
		s_nxt.mon_reg[15:8] = s_nxt.mon_reg[15:8] | mev_set[15:8];
		s_nxt.summary = s_nxt.summary | assert_req;
		s_nxt.sys_stat = s_nxt.sys_stat | sys_set;

		// polarity applied last: bit 3 set means active low
		s_nxt.irq_pin = s_nxt.pin_ctrl[PIC_POL_BIT] ? !assert_req
			: assert_req;
		s_nxt.sys_irq = |(s_nxt.sys_stat & s_nxt.sys_en);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r.pin_ctrl <= PIC_PIN_CTRL_RST;
			s_r.link_reg <= PIC_EV_RST;
			s_r.mon_reg <= PIC_EV_RST;
			s_r.summary <= 1'b0;
			s_r.sys_stat <= PIC_SYS_RST;
			s_r.sys_en <= PIC_SYS_RST;
			s_r.irq_pin <= 1'b1; // idle level for active-low reset polarity
			s_r.sys_irq <= 1'b0;
			s_r.pready <= 1'b0;
			s_r.pslverr <= 1'b0;
			s_r.prdata <= 32'h0000_0000;
		end
		else
			s_r <= s_nxt;
	end

	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign prdata = s_r.prdata;
	assign irq_pin = s_r.irq_pin;
	assign sys_irq = s_r.sys_irq;

endmodule

// >>> rtl/pic_pkg.sv
package pic_pkg;

	// ==========================================
	// register indices (word address = index*4)
	localparam logic [7:0] PIC_IDX_SUMMARY = 8'h10;
	localparam logic [7:0] PIC_IDX_PIN_CTRL = 8'h11;
	localparam logic [7:0] PIC_IDX_LINK_EV = 8'h12;
	localparam logic [7:0] PIC_IDX_MON_EV = 8'h13;
	localparam logic [7:0] PIC_IDX_IRQ_STAT = 8'h14;
	localparam logic [7:0] PIC_IDX_IRQ_CLR = 8'h15;
	localparam logic [7:0] PIC_IDX_IRQ_EN = 8'h16;

	// ==========================================
	// field positions
	localparam int PIC_POL_BIT = 3;
	localparam int PIC_FORCE_BIT = 2;
	localparam int PIC_GEN_BIT = 1;
	localparam int PIC_SUMMARY_BIT = 7;
	localparam int PIC_EN_OFS = 8;

	// flag positions, enable sits 8 bits lower
	localparam logic [15:0] PIC_LINK_FLAGS = 16'h6c00;
	localparam logic [15:0] PIC_MON_FLAGS = 16'hca00;
	localparam logic [15:0] PIC_LINK_MASKS = 16'h006c;
	localparam logic [15:0] PIC_MON_MASKS = 16'h00ca;

	// ==========================================
	// reset values
	localparam logic [15:0] PIC_PIN_CTRL_RST = 16'h000a;
	localparam logic [15:0] PIC_EV_RST = 16'h0000;
	localparam logic [2:0] PIC_SYS_RST = 3'h0;

	// system-interrupt bits: summary, link flags, monitor flags
	localparam int PIC_SYS_SUMMARY = 0;
	localparam int PIC_SYS_LINK = 1;
	localparam int PIC_SYS_MON = 2;

	typedef struct packed {
		logic [15:0] lev;
		logic [15:0] mev;
	} pic_events_t;

	typedef struct packed {
		logic [15:0] pin_ctrl;
		logic [15:0] link_reg;
		logic [15:0] mon_reg;
		logic summary;
		logic [2:0] sys_stat;
		logic [2:0] sys_en;
		logic irq_pin;
		logic sys_irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pic_state_t;

endpackage

// >>> dv/pic_chk.sv
`timescale 1ns/10ps
module pic_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	input wire logic irq_pin
);
	// ==========================================
	// bus and pin checks
	logic pc_wr;
	assign pc_wr = psel && penable && pready && pwrite && paddr == 32'h44;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_setup_answer: assert property (psel && !penable |=> pready)
		else $error("no ready");
	a_ready_once: assert property (pready |=> !pready)
		else $error("long ready");
	a_ready_sel: assert property (pready |-> psel && penable)
		else $error("stray ready");
	a_err_zero: assert property (pslverr |-> pready && (pwrite || !prdata))
		else $error("bad error");
	a_upper_zero: assert property (pready |-> prdata[31:16] == 0)
		else $error("upper bits");
	a_bad_align: assert property (psel && !penable && paddr[1:0] != 0
		|=> pslverr) else $error("no error");
	a_force_pin: assert property (pc_wr && pwdata[3:2] == 2'b11
		|=> ##1 !irq_pin) else $error("no force");
	a_pin_level: assert property (pc_wr && pwdata[2:1] == 0
		|=> ##1 irq_pin == $past(pwdata[3], 2)) else $error("bad level");
	c_error: cover property (pslverr);
	c_forced: cover property (pc_wr && pwdata[2]);
	c_irq: cover property ($fell(irq_pin));
endmodule
bind pic_top pic_chk i_pic_chk(.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .prdata, .irq_pin);

// >>> dv/pic_host.sv
`timescale 1ns/10ps
module pic_host
(
	input wire logic pclk,
	input wire logic irq_pin,
	output logic irq_seen
);
	// host keeps the reset polarity, pin active low
	always_ff @(posedge pclk)
		irq_seen <= !irq_pin;
endmodule

// >>> dv/pic_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
	fail_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module pic_top_tb
	import pic_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, irq_pin, sys_irq, seen, er;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r, ad;
	pic_events_t ev_in = 0;
	int fail_count = 0, n_compared = 0, cyc = 0, e;
	int fb[8] = '{14, 13, 11, 10, 15, 14, 11, 9};
	int sa[8] = '{68, 68, 68, 68, 88, 88, 88, 84};
	int sd[8] = '{12, 4, 0, 10, 7, 0, 7, 7};
	int sx[8] = '{0, 2, 0, 2, 3, 2, 3, 2};
	pic_top i_pic_top(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'hf), .pready, .pslverr, .prdata, .ev_in,
		.irq_pin, .sys_irq);
	pic_host i_pic_host(.pclk, .irq_pin, .irq_seen(seen));
	always #10 pclk = ~pclk;
	// ==========================================
	// bus tasks and closing
	task automatic apb(input logic w, input logic [31:0] a, d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1);
		r = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		// idle edge so the next request never lands in this step
		@(posedge pclk);
	endtask
	task automatic rc(input logic [31:0] a, x);
		apb(0, a, 0);
		`CHK(r, x)
	endtask
	task report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			report_and_stop();
		end
	end
	// ==========================================
	// scenarios
	initial
	begin
		void'($urandom(32'h792a_b79d));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		rc(32'h44, 32'h000a);
		rc(32'h48, 0);
		rc(32'h7c, 0);
		`CHK(er, 1'b1)
		$display("test reset done");
		for (int i = 0; i < 8; i++)
		begin
			e = $urandom % 2;
			ad = 32'h48 + i / 4 * 4;
			apb(1, ad, e << (fb[i] - 8));
			ev_in <= 1 << (fb[i] + (i < 4) * 16);
			@(posedge pclk);
			ev_in <= 0;
			repeat (4) @(posedge pclk);
			`CHK(seen, e[0])
			rc(ad, (e + 256) << (fb[i] - 8));
			rc(ad, e << (fb[i] - 8));
		end
		$display("test events done");
		for (int i = 0; i < 8; i++)
		begin
			if (i == 4)
				rc(32'h50, 32'h0007);
			apb(1, sa[i], sd[i]);
			// pin settles on the idle edge that ends apb; sample it one edge later
			@(posedge pclk);
			`CHK({irq_pin, sys_irq}, sx[i][1:0])
		end
		rc(32'h40, 32'h0080);
		rc(32'h40, 0);
		$display("test pin done");
		report_and_stop();
	end
endmodule
